// [core/piot_pkg.sv]
// Package with offsets, reset values and vectors of the programmable I/O port.
package piot_pkg;

   // ==========================================================================
   // Register word offsets
   // ==========================================================================
   localparam logic [2:0] OFS_LINE_DIRECTION    = 3'h0;
   localparam logic [2:0] OFS_LINE_VALUE        = 3'h1;
   localparam logic [2:0] OFS_UPPER_IRQ_ENABLE  = 3'h2;
   localparam logic [2:0] OFS_TRIGGER_KIND      = 3'h3;
   localparam logic [2:0] OFS_TRIGGER_POLARITY  = 3'h4;
   localparam logic [2:0] OFS_UPPER_IRQ_FLAGS   = 3'h5;
   localparam logic [2:0] OFS_LINE_TRIP_ENABLE  = 3'h6;
   localparam logic [2:0] OFS_CONTROLLER_MASK   = 3'h7;

   // ==========================================================================
   // Field positions, widths and counts
   // ==========================================================================
   localparam int DEDICATED_LINES = 4;
   localparam int MASK_UPPER_BIT  = 4;
   localparam int MASK_WIDTH      = 5;
   localparam int PWM_OUTPUTS     = 6;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [15:0] RST_LINE_DIRECTION   = 16'h0000;
   localparam logic [15:0] RST_LINE_VALUE       = 16'h0000;
   localparam logic [15:0] RST_UPPER_IRQ_ENABLE = 16'h0000;
   localparam logic [15:0] RST_TRIGGER_KIND     = 16'h0000;
   localparam logic [15:0] RST_TRIGGER_POLARITY = 16'h0000;
   localparam logic [15:0] RST_UPPER_IRQ_FLAGS  = 16'h0000;
   localparam logic [15:0] RST_LINE_TRIP_ENABLE = 16'hFFFF;
   localparam logic [4:0]  RST_CONTROLLER_MASK  = 5'h00;

   // ==========================================================================
   // Program memory vectors of the port requests
   // ==========================================================================
   localparam logic [13:0] VEC_NONE    = 14'h0000;
   localparam logic [13:0] VEC_LINE_0  = 14'h0048;
   localparam logic [13:0] VEC_LINE_1  = 14'h004C;
   localparam logic [13:0] VEC_LINE_2  = 14'h0050;
   localparam logic [13:0] VEC_LINE_3  = 14'h0054;
   localparam logic [13:0] VEC_SHARED  = 14'h003C;

endpackage

// [core/piot_sync.sv]
// Two-stage synchroniser with a third stage that holds the previous level.
`timescale 1ns/1ps
module piot_sync #(
   parameter int WIDTH = 12
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out,
   output logic      [WIDTH-1:0] prev_out
);

   // ==========================================================================
   // Stages
   // ==========================================================================
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] prev_reg;

   initial begin
      if (WIDTH < 1) begin
         $error("piot_sync: WIDTH must be at least one");
      end
   end

   // Only the second stage reads the first; edge logic uses stages two and three.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign sync_out = sync_reg;
   assign prev_out = prev_reg;

endmodule

// [core/piot_trip.sv]
// Clockless shutdown combiner with a clocked trip interrupt pulse.
`timescale 1ns/1ps
module piot_trip #(
   parameter int LINES = 12
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [LINES-1:0] pin_in,
   input  wire logic [LINES-1:0] trip_enable,
   output logic                  pwm_shutdown_request,
   output logic [5:0]            pwm_output_disable,
   output logic                  pwm_trip_irq
);

   // ==========================================================================
   // Clockless path
   // ==========================================================================
   // No flop sits in this path, so a lost clock cannot hold off a shutdown.
   assign pwm_shutdown_request = |(~pin_in & trip_enable);
   assign pwm_output_disable   = {piot_pkg::PWM_OUTPUTS{pwm_shutdown_request}};

   // ==========================================================================
   // Trip interrupt
   // ==========================================================================
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;
   logic irq_reg;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
         irq_reg  <= 1'b0;
      end else begin
         meta_reg <= pwm_shutdown_request;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
         irq_reg  <= sync_reg & ~prev_reg;
      end
   end

   assign pwm_trip_irq = irq_reg;

endmodule

// [core/piot_top.sv]
// Twelve-line programmable I/O port with interrupts and PWM shutdown sources.
//
// Operation
// - Direction register, one bit per line; zero is input, one is output.
// - Reset clears all direction bits, so every line starts as input.
// - Written line values drive the pins whose direction selects output.
// - Reading line values returns pin levels for lines set as inputs.
// - Lines 0 to 3 have own requests; lines 4 to 11 share one.
// - Upper enable gates lines 4 to 11; controller mask gates every line request, but not the trip interrupt.
// - Trigger kind one means level sensitive; zero means edge sensitive.
// - Level mode: polarity one is active high, zero active low.
// - Edge mode: polarity one is rising edge, zero falling edge.
// - After reset every line interrupt is disabled.
// - Lines 0 to 3 use vectors 0x0048, 0x004C, 0x0050, 0x0054.
// - Upper line event sets its flag and raises shared request, vector 0x003C.
// - Lines driven as outputs still raise interrupts from their own level.
// - Trip-enabled line held low shuts down all six PWM outputs.
// - Shutdown path from the pins uses no clock at all.
// - Line shutdown raises a trip interrupt; line interrupt may also fire.
// - Reset enables every line as shutdown source.
// - In every register except the controller mask, bit n affects line n only.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module piot_top #(
   parameter int LINES      = 12,
   parameter int DATA_WIDTH = 16
) (
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic [2:0]            reg_addr,
   input  wire logic [DATA_WIDTH-1:0] reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [DATA_WIDTH-1:0] reg_rdata,
   input  wire logic [LINES-1:0]      pin_in,
   output logic      [LINES-1:0]      pin_out,
   output logic      [LINES-1:0]      pin_oe_n,
   output logic      [3:0]            irq_line,
   output logic                       irq_shared,
   output logic      [13:0]           irq_vector,
   output logic                       pwm_shutdown_request,
   output logic      [5:0]            pwm_output_disable,
   output logic                       pwm_trip_irq
);

   // ==========================================================================
   // Elaboration checks
   // ==========================================================================
   initial begin
      if (LINES <= piot_pkg::DEDICATED_LINES || LINES > DATA_WIDTH) begin
         $error("piot_top: LINES must exceed four and fit in DATA_WIDTH");
      end
      if (DATA_WIDTH < piot_pkg::MASK_WIDTH || DATA_WIDTH > 16) begin
         $error("piot_top: DATA_WIDTH must lie between five and sixteen");
      end
   end

   // ==========================================================================
   // Registers
   // ==========================================================================
   logic [LINES-1:0] direction_reg;
   logic [LINES-1:0] value_reg;
   logic [LINES-1:0] upper_enable_reg;
   logic [LINES-1:0] kind_reg;
   logic [LINES-1:0] polarity_reg;
   logic [LINES-1:0] flags_reg;
   logic [LINES-1:0] flags_next;
   logic [LINES-1:0] trip_enable_reg;
   logic [4:0]       mask_reg;
   logic [DATA_WIDTH-1:0] rdata_reg;
   logic [DATA_WIDTH-1:0] rdata_next;
   logic [3:0]       irq_line_reg;
   logic             irq_shared_reg;
   logic [13:0]      vector_reg;
   logic [13:0]      vector_next;

   logic             wr_direction;
   logic             wr_value;
   logic             wr_upper_enable;
   logic             wr_kind;
   logic             wr_polarity;
   logic             wr_trip_enable;
   logic             wr_mask;
   logic             rd_flags;

   logic [LINES-1:0] pin_sync;
   logic [LINES-1:0] pin_prev;
   logic [LINES-1:0] line_event;
   logic [LINES-1:0] upper_set;
   logic [LINES-1:0] readback;

   // ==========================================================================
   // Address decode
   // ==========================================================================
   // Writes to the flag offset find no branch here, so the flags stay read-only.
   always_comb begin
      wr_direction    = 1'b0;
      wr_value        = 1'b0;
      wr_upper_enable = 1'b0;
      wr_kind         = 1'b0;
      wr_polarity     = 1'b0;
      wr_trip_enable  = 1'b0;
      wr_mask         = 1'b0;
      if (reg_addr == piot_pkg::OFS_LINE_DIRECTION) begin
         wr_direction = reg_wr;
      end else if (reg_addr == piot_pkg::OFS_LINE_VALUE) begin
         wr_value = reg_wr;
      end else if (reg_addr == piot_pkg::OFS_UPPER_IRQ_ENABLE) begin
         wr_upper_enable = reg_wr;
      end else if (reg_addr == piot_pkg::OFS_TRIGGER_KIND) begin
         wr_kind = reg_wr;
      end else if (reg_addr == piot_pkg::OFS_TRIGGER_POLARITY) begin
         wr_polarity = reg_wr;
      end else if (reg_addr == piot_pkg::OFS_LINE_TRIP_ENABLE) begin
         wr_trip_enable = reg_wr;
      end else if (reg_addr == piot_pkg::OFS_CONTROLLER_MASK) begin
         wr_mask = reg_wr;
      end
   end

   assign rd_flags = reg_rd & (reg_addr == piot_pkg::OFS_UPPER_IRQ_FLAGS);

   // ==========================================================================
   // Configuration registers
   // ==========================================================================
   always_ff @(posedge clk) begin
      if (!nrst) begin
         direction_reg <= piot_pkg::RST_LINE_DIRECTION[LINES-1:0];
      end else if (wr_direction) begin
         direction_reg <= reg_wdata[LINES-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         value_reg <= piot_pkg::RST_LINE_VALUE[LINES-1:0];
      end else if (wr_value) begin
         value_reg <= reg_wdata[LINES-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         upper_enable_reg <= piot_pkg::RST_UPPER_IRQ_ENABLE[LINES-1:0];
      end else if (wr_upper_enable) begin
         upper_enable_reg <= reg_wdata[LINES-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         mask_reg <= piot_pkg::RST_CONTROLLER_MASK;
      end else if (wr_mask) begin
         mask_reg <= reg_wdata[piot_pkg::MASK_WIDTH-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         kind_reg <= piot_pkg::RST_TRIGGER_KIND[LINES-1:0];
      end else if (wr_kind) begin
         kind_reg <= reg_wdata[LINES-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         polarity_reg <= piot_pkg::RST_TRIGGER_POLARITY[LINES-1:0];
      end else if (wr_polarity) begin
         polarity_reg <= reg_wdata[LINES-1:0];
      end
   end

   // Every line starts as a shutdown source, so open pins hold the outputs off until set up.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         trip_enable_reg <= piot_pkg::RST_LINE_TRIP_ENABLE[LINES-1:0];
      end else if (wr_trip_enable) begin
         trip_enable_reg <= reg_wdata[LINES-1:0];
      end
   end

   // ==========================================================================
   // Pin drive
   // ==========================================================================
   assign pin_out  = value_reg;
   assign pin_oe_n = ~direction_reg;

   // ==========================================================================
   // Input synchronisation and event detection
   // ==========================================================================
   // The pad level is watched even on output lines, so software can raise
   // an interrupt by writing a pattern to a line it drives.
   piot_sync #(
      .WIDTH    (LINES)
   ) u_sync (
      .clk      (clk),
      .nrst     (nrst),
      .async_in (pin_in),
      .sync_out (pin_sync),
      .prev_out (pin_prev)
   );

   genvar gi;
   generate
      for (gi = 0; gi < LINES; gi = gi + 1) begin : g_line
         logic level_hit;
         logic edge_hit;
         assign level_hit = polarity_reg[gi] ? pin_sync[gi] : ~pin_sync[gi];
         assign edge_hit  = polarity_reg[gi] ? (pin_sync[gi] & ~pin_prev[gi])
                                             : (~pin_sync[gi] & pin_prev[gi]);
         assign line_event[gi] = kind_reg[gi] ? level_hit : edge_hit;
      end
   endgenerate

   // ==========================================================================
   // Upper line flags
   // ==========================================================================
   // Flags clear on a read of the flag register; an event in that same cycle
   // sets its flag again so it is never lost.
   always_comb begin
      upper_set = line_event & upper_enable_reg
                & {LINES{mask_reg[piot_pkg::MASK_UPPER_BIT]}};
      upper_set[piot_pkg::DEDICATED_LINES-1:0] = '0;
      flags_next = (rd_flags ? '0 : flags_reg) | upper_set;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         flags_reg <= piot_pkg::RST_UPPER_IRQ_FLAGS[LINES-1:0];
      end else begin
         flags_reg <= flags_next;
      end
   end

   // ==========================================================================
   // Interrupt requests
   // ==========================================================================
   // Edge events give one-cycle requests and level events hold them; the shared
   // request follows the flags, so it stays up until software reads them.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_line_reg <= 4'h0;
      end else begin
         irq_line_reg <= line_event[3:0] & mask_reg[3:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_shared_reg <= 1'b0;
      end else begin
         irq_shared_reg <= |flags_next;
      end
   end

   assign irq_line   = irq_line_reg;
   assign irq_shared = irq_shared_reg;

   // Lower lines win over the shared request; the controller sorts out nesting.
   always_comb begin
      vector_next = piot_pkg::VEC_NONE;
      if (irq_line_reg[0]) begin
         vector_next = piot_pkg::VEC_LINE_0;
      end else if (irq_line_reg[1]) begin
         vector_next = piot_pkg::VEC_LINE_1;
      end else if (irq_line_reg[2]) begin
         vector_next = piot_pkg::VEC_LINE_2;
      end else if (irq_line_reg[3]) begin
         vector_next = piot_pkg::VEC_LINE_3;
      end else if (irq_shared_reg) begin
         vector_next = piot_pkg::VEC_SHARED;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         vector_reg <= piot_pkg::VEC_NONE;
      end else begin
         vector_reg <= vector_next;
      end
   end

   assign irq_vector = vector_reg;

   // ==========================================================================
   // PWM shutdown
   // ==========================================================================
   // The raw pin goes in here, not the synchronised copy, so the trip acts
   // without waiting on any clock edge.
   piot_trip #(
      .LINES                (LINES)
   ) u_trip (
      .clk                  (clk),
      .nrst                 (nrst),
      .pin_in               (pin_in),
      .trip_enable          (trip_enable_reg),
      .pwm_shutdown_request (pwm_shutdown_request),
      .pwm_output_disable   (pwm_output_disable),
      .pwm_trip_irq         (pwm_trip_irq)
   );

   // ==========================================================================
   // Read data
   // ==========================================================================
   // Output lines read back the driven value rather than the pad.
   assign readback = (pin_sync & ~direction_reg) | (value_reg & direction_reg);

   always_comb begin
      rdata_next = '0;
      if (reg_addr == piot_pkg::OFS_LINE_DIRECTION) begin
         rdata_next[LINES-1:0] = direction_reg;
      end else if (reg_addr == piot_pkg::OFS_LINE_VALUE) begin
         rdata_next[LINES-1:0] = readback;
      end else if (reg_addr == piot_pkg::OFS_UPPER_IRQ_ENABLE) begin
         rdata_next[LINES-1:0] = upper_enable_reg;
      end else if (reg_addr == piot_pkg::OFS_TRIGGER_KIND) begin
         rdata_next[LINES-1:0] = kind_reg;
      end else if (reg_addr == piot_pkg::OFS_TRIGGER_POLARITY) begin
         rdata_next[LINES-1:0] = polarity_reg;
      end else if (reg_addr == piot_pkg::OFS_UPPER_IRQ_FLAGS) begin
         rdata_next[LINES-1:0] = flags_reg;
      end else if (reg_addr == piot_pkg::OFS_LINE_TRIP_ENABLE) begin
         rdata_next[LINES-1:0] = trip_enable_reg;
      end else begin
         rdata_next[piot_pkg::MASK_WIDTH-1:0] = mask_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_reg <= '0;
      end else if (reg_rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= '0;
      end
   end

   assign reg_rdata = rdata_reg;

endmodule

// [dv/piot_monitor.sv]
// Checker of the programmable I/O port, bound to its top module.
`timescale 1ns/1ps
module piot_monitor #(
   parameter int LINES      = 12,
   parameter int DATA_WIDTH = 16
) (
   input wire logic                  clk,
   input wire logic                  nrst,
   input wire logic [2:0]            reg_addr,
   input wire logic [DATA_WIDTH-1:0] reg_wdata,
   input wire logic                  reg_wr,
   input wire logic [LINES-1:0]      pin_out,
   input wire logic [LINES-1:0]      pin_oe_n,
   input wire logic [3:0]            irq_line,
   input wire logic                  irq_shared,
   input wire logic [13:0]           irq_vector,
   input wire logic                  pwm_shutdown_request,
   input wire logic [5:0]            pwm_output_disable,
   input wire logic                  pwm_trip_irq
);
   // ==========================================================================
   // Port relations
   // ==========================================================================
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   dir_write_a: assert property (
      reg_wr && reg_addr == 3'h0 |=> pin_oe_n == ~$past(reg_wdata[LINES-1:0]))
      else $error("direction write not seen on output enables");
   value_write_a: assert property (
      reg_wr && reg_addr == 3'h1 |=> pin_out == $past(reg_wdata[LINES-1:0]))
      else $error("value write not seen on pin outputs");
   reset_state_a: assert property ($rose(nrst) |-> pin_oe_n == '1 && irq_line == 4'h0
      && !irq_shared) else $error("state after reset wrong");
   trip_fanout_a: assert property (pwm_output_disable == {6{pwm_shutdown_request}})
      else $error("shutdown not fanned to all six outputs");
   trip_irq_a: assert property ($rose(pwm_shutdown_request) |-> ##[1:5] pwm_trip_irq)
      else $error("trip interrupt missing after shutdown");
   trip_pulse_a: assert property (pwm_trip_irq |=> !pwm_trip_irq)
      else $error("trip interrupt longer than one cycle");
   line0_vector_a: assert property (irq_line[0] |=> irq_vector == 14'h0048)
      else $error("line 0 vector wrong");
   shared_vector_a: assert property (irq_shared && irq_line == 4'h0 |=> irq_vector == 14'h003C)
      else $error("shared vector wrong");

   cover property (irq_shared);
   cover property ($rose(pwm_trip_irq));
   cover property (irq_line[3]);
endmodule

bind piot_top piot_monitor #(.LINES(LINES), .DATA_WIDTH(DATA_WIDTH)) u_piot_monitor (
   .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq_line(irq_line), .irq_shared(irq_shared),
   .irq_vector(irq_vector), .pwm_shutdown_request(pwm_shutdown_request),
   .pwm_output_disable(pwm_output_disable), .pwm_trip_irq(pwm_trip_irq));

// [dv/piot_pins.sv]
// Board side of the port: external drivers and the internal pull-downs.
`timescale 1ns/1ps
module piot_pins (
   input  wire logic [11:0] pin_out,
   input  wire logic [11:0] pin_oe_n,
   input  wire logic [11:0] ext_val,
   input  wire logic [11:0] ext_en,
   output logic      [11:0] pin_level
);
   // ==========================================================================
   // Pin resolution
   // ==========================================================================
   // A line nobody drives falls to the pull-down, so an open line reads low.
   assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val);
endmodule

// [dv/piot_top_test.sv]
// Self-checking testbench of the programmable I/O port.
`timescale 1ns/1ps
module piot_top_test;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [2:0]  reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [11:0] pin_in, pin_out, pin_oe_n;
   logic [11:0] ext_val = 12'h000;
   logic [11:0] ext_en = 12'h000;
   logic [3:0]  irq_line;
   logic        irq_shared, pwm_shutdown_request, pwm_trip_irq, got;
   logic [13:0] irq_vector;
   logic [5:0]  pwm_output_disable;
   int          err_total = 0;
   int          samples_checked = 0;

   always #5 clk = ~clk;

   piot_top u_piot_top (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq_line(irq_line), .irq_shared(irq_shared),
      .irq_vector(irq_vector), .pwm_shutdown_request(pwm_shutdown_request),
      .pwm_output_disable(pwm_output_disable), .pwm_trip_irq(pwm_trip_irq));
   piot_pins u_piot_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
      .ext_en(ext_en), .pin_level(pin_in));

   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   task automatic check(input logic [15:0] g, input logic [15:0] e, input string what);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just there.
   task automatic rd(input logic [2:0] a, input logic [15:0] e, input string what);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, e, what);
   endtask

   task automatic wait_flag(input int n);
      got = 1'b0;
      for (int k = 0; k < 8 && !got; k++) begin
         @(posedge clk);
         #1 got = (n < 4) ? (irq_line[n] === 1'b1) : (pwm_trip_irq === 1'b1);
      end
   endtask

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic t_reset();
      logic [15:0] e [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0FFF, 16'h0};
      for (int i = 0; i < 8; i++) rd(i[2:0], e[i], "reset value");
      check({4'h0, pin_oe_n}, 16'h0FFF, "enables after reset");
      check({15'h0, pwm_shutdown_request}, 16'h0001, "open lines trip");
      $display("reset test done");
   endtask

   task automatic t_dir_data();
      @(posedge clk);
      ext_en <= 12'hFFF;
      ext_val <= 12'hFFF;
      wr(3'h1, 16'h0A5A);
      wr(3'h0, 16'h00F0);
      repeat (3) @(posedge clk);
      #1 check({4'h0, pin_oe_n}, 16'h0F0F, "enables");
      check({4'h0, pin_out & ~pin_oe_n}, 16'h0050, "driven lines");
      rd(3'h1, 16'h0F5F, "line value");
      wr(3'h0, 16'h0000);
      $display("direction test done");
   endtask

   task automatic t_dedicated();
      logic [13:0] vec [4] = '{14'h0048, 14'h004C, 14'h0050, 14'h0054};
      @(posedge clk);
      ext_val[3:0] <= 4'hA;
      wr(3'h3, 16'h000C);
      wr(3'h4, 16'h0005);
      wr(3'h7, 16'h000F);
      repeat (4) @(posedge clk);
      for (int n = 0; n < 4; n++) begin
         @(posedge clk);
         ext_val[n] <= ~ext_val[n];
         wait_flag(n);
         check({15'h0, got}, 16'h0001, "dedicated request");
         @(posedge clk);
         #1 check({2'h0, irq_vector}, {2'h0, vec[n]}, "dedicated vector");
         @(posedge clk);
         ext_val[n] <= ~ext_val[n];
         repeat (5) @(posedge clk);
      end
      wr(3'h7, 16'h0000);
      wr(3'h3, 16'h0000);
      wr(3'h4, 16'h0000);
      $display("dedicated test done");
   endtask

   task automatic t_shared();
      wr(3'h1, 16'h0080);
      wr(3'h0, 16'h0080);
      wr(3'h2, 16'h00A0);
      wr(3'h7, 16'h0010);
      rd(3'h5, 16'h0000, "flags idle");
      @(posedge clk);
      ext_val[6:5] <= 2'h0;
      wr(3'h1, 16'h0000);
      repeat (4) @(posedge clk);
      #1 check({15'h0, irq_shared}, 16'h0001, "shared request");
      rd(3'h5, 16'h00A0, "flags");
      rd(3'h5, 16'h0000, "flags cleared");
      check({15'h0, irq_shared}, 16'h0000, "shared request cleared");
      wr(3'h2, 16'h0000);
      wr(3'h7, 16'h0000);
      wr(3'h0, 16'h0000);
      $display("shared test done");
   endtask

   task automatic t_trip();
      wr(3'h6, 16'h0001);
      @(posedge clk);
      ext_val <= 12'hFFF;
      repeat (3) @(posedge clk);
      ext_val[4] <= 1'b0;
      #1 check({15'h0, pwm_shutdown_request}, 16'h0000, "disabled line");
      repeat (6) @(posedge clk);
      ext_val[0] <= 1'b0;
      // Sampled before the next edge, so a clocked path could not pass.
      #1 check({9'h0, pwm_shutdown_request, pwm_output_disable}, 16'h007F, "trip");
      wait_flag(4);
      check({15'h0, got}, 16'h0001, "trip interrupt");
      $display("trip test done");
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #100000;
      err_total++;
      end_of_test();
   end

   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_dir_data();
      t_dedicated();
      t_shared();
      t_trip();
      end_of_test();
   end
endmodule
